// ==== inc/sarrd_pkg.sv ====
`default_nettype none
package sarrd_pkg;
  // Clock rate and derived cycle counts
  localparam int CLK_MHZ = 40;
  localparam int CONV_NS = 180;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int ACQ_NS = 70;
  localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int START_LOW_NS = 20;
  localparam int START_LOW_CYC = (START_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_MAX_NS = 500;
  localparam int RESET_MAX_CYC = (RESET_MAX_NS * CLK_MHZ) / 1000;
  localparam int SLEEP_MIN_NS = 1500;
  localparam int SLEEP_MIN_CYC = (SLEEP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_NS = 5000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESUME_NS = 100;
  localparam int RESUME_CYC = (RESUME_NS * CLK_MHZ + 999) / 1000;
  localparam int BUF_WAKE_MS = 25;
  localparam int BUF_WAKE_CYC = BUF_WAKE_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 8;
  localparam int CNT_TOP = CONV_CYC - 1;
  // Result width and reset values
  localparam int RES_W = 16;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] FILL_ONES = 8'hFF;
  localparam logic [15:0] SAR_START = 16'h8000;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    SARRD_ACQ = 2'b00,
    SARRD_CONV = 2'b01,
    SARRD_WAIT_HIGH = 2'b10,
    SARRD_SLEEP = 2'b11
  } sarrd_state_t;
endpackage
`default_nettype wire

// ==== src/sarrd_core.sv ====
`default_nettype none
// Summary of operation
// - Busy high throughout conversion, low otherwise
// - Active-low start, independent of chip select
// - Byte select folds low byte onto top
// - Drive bus only while select and read low
// - Conversion finishes within 180 ns
// - Conversion clock generated internally
// - Input sampled at start, then disconnected
// - Acquisition window of 70 ns
// - Core and buffer sleep controls; buffers sleep only while both are asserted
// - Start low 20 ns (code needs two clock samples low); busy rises on the fourth clock edge after the pin falls
// - Short low resets; long low sleeps core
// - Result coded in two's complement
module sarrd_core
  import sarrd_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic byte_select,
  input wire logic core_sleep_n,
  input wire logic analog_buffer_sleep_n,
  input wire logic [2:0] comparator_in, // Count of seven sub-levels that the held input reaches
  output logic busy,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  output logic sample_connect,
  output logic core_powered,
  output logic buffers_powered,
  output logic sar_strobe,
  output logic [15:0] sar_trial
);
  logic start_s;
  logic sleep_s;
  logic buf_s;
  logic start_prev;
  logic start_fall;
  sarrd_state_t state;
  sarrd_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] acq_count;
  logic [CNT_W-1:0] next_acq_count;
  logic [CNT_W-1:0] sleep_count;
  logic [CNT_W-1:0] next_sleep_count;
  logic [15:0] sar;
  logic [15:0] next_sar;
  logic [15:0] bit_mask;
  logic [15:0] next_bit_mask;
  logic [15:0] result;
  logic [15:0] next_result;
  logic [15:0] bus_word;
  logic [15:0] next_bus_word;
  logic bus_en;
  logic next_bus_en;
  logic busy_q;
  logic next_busy_q;
  logic next_start_prev;
  logic acq_done;
  logic start_go;
  logic [15:0] group_mask;
  logic [15:0] group_bits;

  // Pin inputs cross into the clock domain
  sarrd_sync #(.INIT(1'b1)) u_sync_start (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(conversion_start_n),
    .sync_out(start_s)
  );
  sarrd_sync #(.INIT(1'b1)) u_sync_sleep (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(core_sleep_n),
    .sync_out(sleep_s)
  );
  sarrd_sync #(.INIT(1'b1)) u_sync_buf (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(analog_buffer_sleep_n),
    .sync_out(buf_s)
  );

  // Falling edge of start; chip select plays no part
  assign start_fall = start_prev & ~start_s;

  // A start is honoured once the input has been tracked for the full window
  assign acq_done = (acq_count >= CNT_W'(ACQ_CYC));
  assign start_go = start_fall & acq_done;

  // Multi-bit step: three result bits per cycle, the last step resolves bit 0 only
  assign group_mask = bit_mask | (bit_mask >> 1) | (bit_mask >> 2);
  assign group_bits = (comparator_in[2] ? bit_mask : 16'h0000) |
                      (comparator_in[1] ? (bit_mask >> 1) : 16'h0000) |
                      (comparator_in[0] ? (bit_mask >> 2) : 16'h0000);

  // Sequencer next state: acquire, convert, sleep
  always_comb begin
    next_state = state;
    next_count = count;
    next_acq_count = acq_count;
    next_sar = sar;
    next_bit_mask = bit_mask;
    next_result = result;
    next_busy_q = busy_q;
    next_start_prev = start_s;
    next_sleep_count = sleep_s ? '0 : ((sleep_count == CNT_W'(SLEEP_MIN_CYC)) ?
                       sleep_count : sleep_count + 8'h01);
    if (!sleep_s) begin
      // Low pin aborts at once; held long it sleeps the core
      next_busy_q = 1'b0;
      next_state = SARRD_WAIT_HIGH;
      next_count = '0;
      if (sleep_count >= CNT_W'(SLEEP_MIN_CYC - 1)) begin
        next_state = SARRD_SLEEP;
      end
    end else begin
      case (state)
        SARRD_ACQ: begin
          if (acq_count < CNT_W'(ACQ_CYC)) begin
            next_acq_count = acq_count + 8'h01;
          end
          if (start_go) begin
            next_state = SARRD_CONV;
            next_busy_q = 1'b1;
            next_count = '0;
            next_sar = SAR_START;
            next_bit_mask = SAR_START;
          end
        end
        SARRD_CONV: begin
          // Internal divider sequences bit trials
          next_count = count + 8'h01;
          if (bit_mask != 16'h0000) begin
            // Clear the group, load its decision, set the next group's trial bit
            next_sar = (sar & ~group_mask) | group_bits | (bit_mask >> 3);
            next_bit_mask = bit_mask >> 3;
          end
          // The start-edge cycle is already busy, so the last step ends one count early
          if (count == CNT_W'(CNT_TOP - 1)) begin
            // Flip sign bit: offset binary to two's complement
            next_result = {~next_sar[15], next_sar[14:0]};
            next_busy_q = 1'b0;
            next_acq_count = '0;
            next_state = start_s ? SARRD_ACQ : SARRD_WAIT_HIGH;
          end
        end
        SARRD_WAIT_HIGH: begin
          next_acq_count = '0;
          if (start_s) begin
            next_state = SARRD_ACQ;
          end
        end
        SARRD_SLEEP: begin
          next_state = SARRD_WAIT_HIGH;
        end
        default: begin
          next_state = SARRD_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= SARRD_ACQ;
      count <= '0;
      acq_count <= '0;
      sleep_count <= '0;
      sar <= SAR_START;
      bit_mask <= '0;
      result <= RESULT_RST;
      busy_q <= 1'b0;
      start_prev <= 1'b1;
    end else begin
      state <= next_state;
      count <= next_count;
      acq_count <= next_acq_count;
      sleep_count <= next_sleep_count;
      sar <= next_sar;
      bit_mask <= next_bit_mask;
      result <= next_result;
      busy_q <= next_busy_q;
      start_prev <= next_start_prev;
    end
  end

  // Busy follows the edge combinationally, then the register holds it
  assign busy = busy_q | (start_go & sleep_s & (state == SARRD_ACQ));

  // Input connected only outside conversion and sleep, held from the start edge on
  assign sample_connect = (state == SARRD_ACQ) && sleep_s && !start_go;
  assign sar_strobe = (state == SARRD_CONV) && (bit_mask != 16'h0000);
  assign sar_trial = sar;
  assign core_powered = (state != SARRD_SLEEP);
  assign buffers_powered = buf_s | sleep_s;

  // Output word and enable, registered
  always_comb begin
    next_bus_word = byte_select ? {result[7:0], FILL_ONES} : result;
    next_bus_en = ~chip_select_n & ~read_n & (state != SARRD_SLEEP);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bus_word <= RESULT_RST;
      bus_en <= 1'b0;
    end else begin
      bus_word <= next_bus_word;
      bus_en <= next_bus_en;
    end
  end

  assign data_out = bus_word;
  assign data_oe = {RES_W{bus_en}};
endmodule // sarrd_core
`default_nettype wire

// ==== src/sarrd_sync.sv ====
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module sarrd_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_sync_out;

  // Shift chain and agreement filter
  always_comb begin
    next_stage = {stage[1:0], async_in};
    next_sync_out = (stage[2] == stage[1]) ? stage[2] : sync_out;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stage <= {3{INIT}};
      sync_out <= INIT;
    end else begin
      stage <= next_stage;
      sync_out <= next_sync_out;
    end
  end
endmodule // sarrd_sync
`default_nettype wire

// ==== test/sarrd_chk.sv ====
`default_nettype none
module sarrd_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic byte_select,
  input wire logic core_sleep_n,
  input wire logic busy,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic sample_connect,
  input wire logic core_powered,
  input wire logic sar_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Busy stands for the whole conversion, then drops
  sequence conv_s;
    busy [*7] ##1 !busy;
  endsequence
  chk_busy_len: assert property (@(posedge clock) disable iff (!reset_n || !core_sleep_n)
    $rose(busy) |-> conv_s) else $error("busy length wrong");
  chk_bus_off: assert property (@(posedge clock) disable iff (!reset_n)
    (chip_select_n || read_n) |=> data_oe == 16'h0000) else $error("bus driven");
  chk_bus_on: assert property (@(posedge clock) disable iff (!reset_n)
    (!chip_select_n && !read_n && core_powered) |=> data_oe == 16'hFFFF) else $error("bus off");
  chk_byte_fold: assert property (@(posedge clock) disable iff (!reset_n)
    (data_oe[0] && byte_select && $past(byte_select)) |-> data_out[7:0] == 8'hFF)
    else $error("low byte not ones");
  chk_hold_open: assert property (@(posedge clock) disable iff (!reset_n)
    busy |-> !sample_connect) else $error("input tracked in conversion");
  chk_start_busy: assert property (@(posedge clock) disable iff (!reset_n)
    ($fell(conversion_start_n) && sample_connect) |-> ##[1:4] busy) else $error("no busy");
  chk_sleep_bus: assert property (@(posedge clock) disable iff (!reset_n)
    !core_powered [*2] |-> data_oe == 16'h0000) else $error("bus on in sleep");
  chk_strobe_busy: assert property (@(posedge clock) disable iff (!reset_n)
    sar_strobe |-> busy) else $error("trial outside busy");
endmodule // sarrd_chk
bind sarrd_core sarrd_chk chk_u (.clock(clock), .reset_n(reset_n),
  .conversion_start_n(conversion_start_n), .chip_select_n(chip_select_n), .read_n(read_n),
  .byte_select(byte_select), .core_sleep_n(core_sleep_n), .busy(busy), .data_out(data_out),
  .data_oe(data_oe), .sample_connect(sample_connect), .core_powered(core_powered),
  .sar_strobe(sar_strobe));
`default_nettype wire

// ==== test/sarrd_comp_model.sv ====
`default_nettype none
module sarrd_comp_model (
  input wire logic [15:0] sar_trial,
  input wire logic [15:0] level,
  output logic [2:0] comparator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] trial_bit;
  logic [15:0] base;
  logic [18:0] steps;
  // Lowest set bit of the trial word marks the top bit of the group under test
  assign trial_bit = sar_trial & (~sar_trial + 16'h0001);
  assign base = sar_trial ^ trial_bit;
  // Seven comparators at quarter-weight steps above the decided bits; count those reached
  assign steps = (trial_bit == 16'h0000) ? 19'h00000 :
                 ({3'h0, 16'(level - base)} << 2) / {3'h0, trial_bit};
  assign comparator_in = (steps > 19'h00007) ? 3'h7 : steps[2:0];
endmodule // sarrd_comp_model
`default_nettype wire

// ==== test/sarrd_core_test.sv ====
`default_nettype none
module sarrd_core_test
  import sarrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, conversion_start_n, chip_select_n, read_n, byte_select;
  logic core_sleep_n, analog_buffer_sleep_n, busy, sample_connect;
  logic [2:0] comparator_in;
  logic core_powered, buffers_powered, sar_strobe;
  logic [15:0] data_out, data_oe, sar_trial, level, r;
  int bad_count, n_compared, n;
  logic [15:0] level_tab [3] = '{16'hFFFF, 16'h0000, 16'hA5C3};
  sarrd_core dut_u (.clock(clock), .reset_n(reset_n), .conversion_start_n(conversion_start_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .byte_select(byte_select),
    .core_sleep_n(core_sleep_n), .analog_buffer_sleep_n(analog_buffer_sleep_n),
    .comparator_in(comparator_in), .busy(busy), .data_out(data_out), .data_oe(data_oe),
    .sample_connect(sample_connect), .core_powered(core_powered),
    .buffers_powered(buffers_powered), .sar_strobe(sar_strobe), .sar_trial(sar_trial));
  sarrd_comp_model comp_u (.sar_trial(sar_trial), .level(level), .comparator_in(comparator_in));
  // Clock of 25 ns
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_busy(logic v);
    int i;
    i = 0;
    while (busy !== v && i < 40) begin
      @(negedge clock);
      i++;
    end
    if (i == 40) begin
      bad_count++;
      finish_test();
    end
  endtask
  // Start with the given select level, then count busy cycles
  task automatic convert(logic [15:0] lv, logic cs);
    level = lv;
    chip_select_n = cs;
    @(negedge clock) conversion_start_n = 0;
    wait_busy(1);
    n = 0;
    while (busy === 1'b1 && n < 20) @(negedge clock) n++;
    check(16'(n), 16'(CONV_CYC));
    conversion_start_n = 1;
    chip_select_n = 1;
    repeat (8) @(negedge clock);
  endtask
  task automatic read(logic bs, logic [15:0] exp);
    byte_select = bs;
    chip_select_n = 0;
    read_n = 0;
    repeat (2) @(negedge clock);
    check(data_oe, 16'hFFFF);
    check(data_out, exp);
    chip_select_n = 1;
    read_n = 1;
    repeat (2) @(negedge clock);
    check(data_oe, 16'h0000);
  endtask
  // Main sequence
  initial begin
    {reset_n, byte_select, level, bad_count, n_compared} = '0;
    {conversion_start_n, chip_select_n, read_n, core_sleep_n, analog_buffer_sleep_n} = '1;
    repeat (5) @(negedge clock);
    reset_n = 1;
    repeat (4) @(negedge clock);
    foreach (level_tab[i]) begin
      convert(level_tab[i], i[0]);
      r = level_tab[i] ^ 16'h8000;
      read(0, r);
      read(1, {r[7:0], 8'hFF});
    end
    level = 16'h1234;
    conversion_start_n = 0;
    wait_busy(1);
    core_sleep_n = 0;
    repeat (6) @(negedge clock);
    check(busy, 0);
    {core_sleep_n, conversion_start_n} = 2'b11;
    // Short reset over: the first trusted conversion comes after the resume time
    repeat (RESUME_CYC + 4) @(negedge clock);
    convert(16'h1234, 1);
    read(0, 16'h9234);
    core_sleep_n = 0;
    repeat (70) @(negedge clock);
    check(core_powered, 0);
    check(buffers_powered, 1);
    {conversion_start_n, chip_select_n, read_n} = 3'b000;
    repeat (4) @(negedge clock) analog_buffer_sleep_n = 0;
    check(busy, 0);
    check(data_oe, 16'h0000);
    {conversion_start_n, chip_select_n, read_n} = 3'b111;
    repeat (70) @(negedge clock);
    check(buffers_powered, 0);
    {core_sleep_n, analog_buffer_sleep_n} = 2'b11;
    // Core wake time before trusting results; buffer outputs are never relied on here
    repeat (WAKE_CYC) @(negedge clock);
    check(core_powered & buffers_powered, 1);
    convert(16'h0000, 0);
    read(0, 16'h8000);
    finish_test();
  end
endmodule // sarrd_core_test
`default_nettype wire
